// ---- rx_fifo_if.sv ----
// carrier between the receiver and its word buffer
`timescale 1ns/1ns
interface rx_fifo_if;
  import uart_rx_pkg::*;
  logic     push;
  rx_word_t push_word;
  logic     pop;
  logic     full;
  logic     empty;
  rx_word_t head;
  modport writer (output push, output push_word, output pop, input full, input empty, input head);
  modport store  (input push, input push_word, input pop, output full, output empty, output head);
endinterface : rx_fifo_if

// ---- rx_word_fifo.sv ----
// shift-style word buffer; the head word sits in a register
`timescale 1ns/1ns
module rx_word_fifo
  import uart_rx_pkg::*;
#(
  parameter int DEPTH = 2
)(
  input wire logic   clk,
  input wire logic   rst,
  rx_fifo_if.store   port
);
  localparam int CW = $clog2(DEPTH + 1);
  logic [CW-1:0] count;
  rx_word_t      slot [DEPTH];
  logic          push_ok;

  // a pop in the same cycle frees room for the incoming word
  assign push_ok    = port.push && ((count != CW'(DEPTH)) || port.pop);
  assign port.full  = (count == CW'(DEPTH));
  assign port.empty = (count == '0);
  assign port.head  = slot[0];

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count <= '0;
    else if (push_ok && !port.pop)
      count <= count + CW'(1);
    else if (!push_ok && port.pop)
      count <= count - CW'(1);
  end

  //------------------------------------------------------------
  // storage entries
  //------------------------------------------------------------
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_slot
    always_ff @(posedge clk or posedge rst)
    begin
      if (rst)
        slot[i] <= '0;
      else if (port.pop)
      begin
        if (push_ok && (CW'(i + 1) == count))
          slot[i] <= port.push_word;
        else if (i < DEPTH - 1)
          slot[i] <= slot[(i < DEPTH - 1) ? i + 1 : i];
      end
      else if (push_ok && (CW'(i) == count))
        slot[i] <= port.push_word;
    end
  end
endmodule : rx_word_fifo

// ---- serial_sender.sv ----
// remote serial transmitter driving the shared receive pin
`timescale 1ns/1ns
module serial_sender (
  input wire logic clk,
  output logic     line
);
  // line idles high between frames, as the pull-up holds it
  initial line = 1'b1;

  //------------------------------------------------------------
  // one bit time is 16 oversample ticks with baud divisor 0
  //------------------------------------------------------------
  task automatic bit_out(input logic v, input logic glitch);
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      // one-tick glitch near mid-bit: majority survives, disagreement seen
      line <= (glitch && i == 10) ? ~v : v;
    end
  endtask : bit_out

  task automatic send(input logic [8:0] d, input logic nine, input logic two, input int par,
                      input logic bad_par, input logic bad_stop, input logic noisy);
    logic p;
    p = (nine ? ^d : ^d[7:0]) ^ (par == 2) ^ bad_par;
    bit_out(1'b0, 1'b0);
    for (int b = 0; b < (nine ? 9 : 8); b++)
      bit_out(d[b], noisy && b == 0);
    if (par != 0)
      bit_out(p, 1'b0);
    bit_out(!(bad_stop && !two), 1'b0);
    if (two)
      bit_out(!bad_stop, 1'b0);
    // back to idle high so a broken stop does not look like a start
    bit_out(1'b1, 1'b0);
  endtask : send
endmodule : serial_sender

// ---- uart_rx_consts.svh ----
// constants for the receive, error, interrupt and wake-up block
//------------------------------------------------------------
// Functional notes
//------------------------------------------------------------
// Functional notes
// - noise flag rises together with the receive-data-ready flag.
// - a noisy frame is still stored as a normal character.
// - noise alone raises no interrupt.
// - noise flag clears on status read then data buffer read.
// - zero at any stop bit position sets framing error.
// - framing error stored with its word; reset clears it.
// - parity error set on wrong parity when parity enabled; reset clears.
// - interrupt request is a low pulse from six conditions.
// - transmit conditions have own enables; receive conditions share one.
// - address detect interrupts with no flag, only in address mode.
// - clock stopped plus enables: falling pin edge raises wake-up interrupt.
// - status flags read-only, cleared only by access sequences.
// - address mode: data interrupt only when highest word bit is one.
// - without address mode every ready setting raises data interrupt.
// - stopped clock freezes reception; it resumes when clock returns.
// - idle or sleep leaves all registers unchanged.
// - data on the pin during clock recovery is discarded.
// - wake-up interrupts only with global and uart enables set.
// - wake-up interrupt waits until recovery cycles elapse.
// - ready flag clears on status access then data buffer read.
// - two words buffered; third completing sets overrun, buffer kept.
`ifndef UART_RX_CONSTS_SVH
`define UART_RX_CONSTS_SVH
`define REG_STATUS   3'h0
`define REG_CTRL1    3'h1
`define REG_CTRL2    3'h2
`define REG_CTRL3    3'h3
`define REG_DATA     3'h4
`define REG_BAUD     3'h5
`define ST_PARITY_ERROR_FLAG      0
`define ST_NOISE     1
`define ST_FRAMING_ERROR_FLAG      2
`define ST_OVR       3
`define ST_RIDLE     4
`define ST_READY     5
`define ST_TIDLE     6
`define ST_TEMPTY    7
`define C1_NINE      0
`define C1_PAREN     1
`define C1_PODD      2
`define C1_TWOSTOP   3
`define C1_UART_ENABLE      4
`define C1_BIT8      5
`define C2_RECEIVER_ENABLE      0
`define C2_ADDR      1
`define C2_RIE       2
`define C2_WAKE      3
`define C2_TEIE      4
`define C2_TIIE      5
`define C3_GLOBAL    0
`define C3_UART      1
`define CTRL_RESET   8'h00
`define BAUD_RESET   8'h00
`define OS_SAMPLE0   4'h7
`define OS_SAMPLE1   4'h8
`define OS_DECIDE    4'h9
`define BITS_EIGHT   4'h8
`define BITS_NINE    4'h9
`endif

// ---- uart_rx_error_irq_wakeup.sv ----
// receiver with error flags, interrupt merge, address filter and pin wake-up
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "uart_rx_consts.svh"
module uart_rx_error_irq_wakeup
  import uart_rx_pkg::*;
#(
  parameter int RECOVERY_CYCLES = 16,
  parameter int WORD_DEPTH      = 2
)(
  input  wire logic       CLOCK,
  input  wire logic       RST,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       RXTX,
  input  wire logic       CLK_STOP,
  input  wire logic       TX_EMPTY,
  input  wire logic       TX_IDLE,
  output logic            IRQ_N,
  output logic            WAKE
);
  localparam logic [7:0] RECOVERY_LOAD = 8'(RECOVERY_CYCLES);

  rx_fifo_if fifo ();

  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] ctrl3;
  logic [7:0] baud;
  logic [7:0] div_cnt;
  logic       rx_meta;
  logic       rx_sync;
  logic       rx_prev;
  rx_state_t  state;
  logic [3:0] os_cnt;
  logic [3:0] bit_cnt;
  logic [1:0] samp;
  logic [8:0] shift;
  logic       noise_acc;
  logic       framing_error_flag_acc;
  logic       parity_error_flag_acc;
  logic       par_acc;
  logic       ovr_flag;
  logic       armed;
  logic [7:0] recov_cnt;
  logic       wake_pend;
  logic       avail_evt;
  logic       ovr_evt;
  logic       addr_evt;
  logic       wake_fire;
  logic       tx_empty_prev;
  logic       tx_idle_prev;
  logic       tick;
  logic       active;
  logic       maj;
  logic       noisy;
  logic       decide;
  logic       last_stop;
  logic       rx_enabled;
  logic       push_ok;
  logic       msb;
  logic       wake_armed;
  logic       irq_any;
  logic [7:0] status;
  logic [3:0] nbits;
  logic [8:0] next_shift;
  rx_word_t   next_word;

  rx_word_fifo #(
    .DEPTH (WORD_DEPTH)
  ) u_fifo (
    .clk  (CLOCK),
    .rst  (RST),
    .port (fifo.store)
  );

  //------------------------------------------------------------
  // pin synchroniser and oversampling tick
  //------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_meta <= RXTX;
      rx_sync <= rx_meta;
      rx_prev <= rx_sync;
    end
  end

  // a stopped uart clock halts the divider and the receiver in place
  assign active = !CLK_STOP;
  assign tick   = active && (div_cnt == baud);

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      div_cnt <= 8'h00;
    else if (active)
      div_cnt <= tick ? 8'h00 : div_cnt + 8'h01;
  end

  //------------------------------------------------------------
  // receive state machine
  //------------------------------------------------------------
  assign rx_enabled = ctrl1[`C1_UART_ENABLE] && ctrl2[`C2_RECEIVER_ENABLE] && (recov_cnt == 8'h00);
  assign maj        = (samp[0] & samp[1]) | (samp[0] & rx_sync) | (samp[1] & rx_sync);
  assign noisy      = !((samp[0] == samp[1]) && (samp[1] == rx_sync));
  assign decide     = tick && (os_cnt == `OS_DECIDE);
  assign nbits      = ctrl1[`C1_NINE] ? `BITS_NINE : `BITS_EIGHT;
  assign next_shift = {maj, shift[8:1]};
  assign last_stop  = (state == RX_STOP2) || ((state == RX_STOP1) && !ctrl1[`C1_TWOSTOP]);
  assign msb        = ctrl1[`C1_NINE] ? fifo.push_word.data[8] : fifo.push_word.data[7];

  always_comb
  begin
    next_word       = '0;
    next_word.data  = ctrl1[`C1_NINE] ? shift : {1'b0, shift[8:1]};
    next_word.noise = noise_acc | noisy;
    next_word.framing_error_flag  = framing_error_flag_acc | !maj;
    next_word.parity_error_flag  = parity_error_flag_acc;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      state     <= RX_IDLE;
      os_cnt    <= 4'h0;
      bit_cnt   <= 4'h0;
      samp      <= 2'b11;
      shift     <= 9'h000;
      noise_acc <= 1'b0;
      framing_error_flag_acc  <= 1'b0;
      parity_error_flag_acc  <= 1'b0;
      par_acc   <= 1'b0;
    end
    else if (!rx_enabled)
      state <= RX_IDLE;
    else if (active)
    begin
      if (tick)
        os_cnt <= os_cnt + 4'h1;
      if (tick && (os_cnt == `OS_SAMPLE0))
        samp[0] <= rx_sync;
      if (tick && (os_cnt == `OS_SAMPLE1))
        samp[1] <= rx_sync;
      case (state)
        RX_IDLE:
        begin
          if (!rx_sync)
          begin
            state     <= RX_START;
            os_cnt    <= 4'h0;
            noise_acc <= 1'b0;
            framing_error_flag_acc  <= 1'b0;
            parity_error_flag_acc  <= 1'b0;
            par_acc   <= 1'b0;
            bit_cnt   <= 4'h0;
          end
        end
        RX_START:
        begin
          if (decide)
          begin
            noise_acc <= noisy;
            state     <= maj ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (decide)
          begin
            shift     <= next_shift;
            par_acc   <= par_acc ^ maj;
            noise_acc <= noise_acc | noisy;
            bit_cnt   <= bit_cnt + 4'h1;
            if (bit_cnt + 4'h1 == nbits)
              state <= ctrl1[`C1_PAREN] ? RX_PARITY : RX_STOP1;
          end
        end
        RX_PARITY:
        begin
          if (decide)
          begin
            parity_error_flag_acc  <= par_acc ^ maj ^ ctrl1[`C1_PODD];
            noise_acc <= noise_acc | noisy;
            state     <= RX_STOP1;
          end
        end
        RX_STOP1, RX_STOP2:
        begin
          if (decide)
          begin
            noise_acc <= noise_acc | noisy;
            framing_error_flag_acc  <= framing_error_flag_acc | !maj;
            if (last_stop)
              state <= maj ? RX_IDLE : RX_BREAK;
            else
              state <= RX_STOP2;
          end
        end
        // a held-low line is one frame; wait for a high before a new start
        RX_BREAK:
        begin
          if (rx_sync)
            state <= RX_IDLE;
        end
        default:
          state <= RX_IDLE;
      endcase
    end
  end

  // the word goes to the buffer on the last stop sample, noisy or not
  assign fifo.push      = rx_enabled && active && decide && last_stop;
  assign fifo.push_word = next_word;
  assign fifo.pop       = RD && (ADDR == `REG_DATA) && armed && !fifo.empty;
  assign push_ok        = fifo.push && (!fifo.full || fifo.pop);

  //------------------------------------------------------------
  // status access sequence and overrun
  //------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      armed <= 1'b0;
    else if (RD && (ADDR == `REG_STATUS))
      armed <= 1'b1;
    else if (RD && (ADDR == `REG_DATA))
      armed <= 1'b0;
  end

  // a pop in the clearing cycle frees room, so a push then is stored and the clear wins
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      ovr_flag <= 1'b0;
    else if (fifo.push && !push_ok)
      ovr_flag <= 1'b1;
    else if (fifo.pop)
      ovr_flag <= 1'b0;
  end

  //------------------------------------------------------------
  // register file
  //------------------------------------------------------------
  // power-down touches none of these; only reset and writes do
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      ctrl1 <= `CTRL_RESET;
      ctrl2 <= `CTRL_RESET;
      ctrl3 <= `CTRL_RESET;
      baud  <= `BAUD_RESET;
    end
    else if (WR)
    begin
      case (ADDR)
        `REG_CTRL1: ctrl1 <= WDATA;
        `REG_CTRL2: ctrl2 <= WDATA;
        `REG_CTRL3: ctrl3 <= WDATA;
        `REG_BAUD:  baud  <= WDATA;
        default:    ;
      endcase
    end
  end

  // flags follow the head word, so a pop shows the next word's errors
  always_comb
  begin
    status              = 8'h00;
    status[`ST_PARITY_ERROR_FLAG]    = !fifo.empty && fifo.head.parity_error_flag;
    status[`ST_NOISE]   = !fifo.empty && fifo.head.noise;
    status[`ST_FRAMING_ERROR_FLAG]    = !fifo.empty && fifo.head.framing_error_flag;
    status[`ST_OVR]     = ovr_flag;
    status[`ST_RIDLE]   = (state == RX_IDLE);
    status[`ST_READY]   = !fifo.empty;
    status[`ST_TIDLE]   = TX_IDLE;
    status[`ST_TEMPTY]  = TX_EMPTY;
  end

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      RDATA <= 8'h00;
    else if (RD)
    begin
      case (ADDR)
        `REG_STATUS: RDATA <= status;
        `REG_CTRL1:  RDATA <= {ctrl1[7:`C1_BIT8 + 1], fifo.head.data[8], ctrl1[`C1_BIT8 - 1:0]};
        `REG_CTRL2:  RDATA <= ctrl2;
        `REG_CTRL3:  RDATA <= ctrl3;
        `REG_DATA:   RDATA <= fifo.head.data[7:0];
        `REG_BAUD:   RDATA <= baud;
        default:     RDATA <= 8'h00;
      endcase
    end
    else
      RDATA <= 8'h00;
  end

  //------------------------------------------------------------
  // wake-up and recovery
  //------------------------------------------------------------
  assign wake_armed = CLK_STOP && ctrl1[`C1_UART_ENABLE] && ctrl2[`C2_RECEIVER_ENABLE] && ctrl2[`C2_RIE] && ctrl2[`C2_WAKE];

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      WAKE      <= 1'b0;
      recov_cnt <= 8'h00;
      wake_pend <= 1'b0;
    end
    else
    begin
      WAKE <= 1'b0;
      if (wake_armed && rx_prev && !rx_sync)
      begin
        WAKE      <= 1'b1;
        recov_cnt <= RECOVERY_LOAD;
        wake_pend <= 1'b1;
      end
      else if (!CLK_STOP && (recov_cnt != 8'h00))
        recov_cnt <= recov_cnt - 8'h01;
      else if (recov_cnt == 8'h00)
        wake_pend <= 1'b0;
    end
  end

  assign wake_fire = wake_pend && (recov_cnt == 8'h00);

  //------------------------------------------------------------
  // interrupt merge
  //------------------------------------------------------------
  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
    begin
      avail_evt     <= 1'b0;
      ovr_evt       <= 1'b0;
      addr_evt      <= 1'b0;
      tx_empty_prev <= 1'b0;
      tx_idle_prev  <= 1'b0;
    end
    else
    begin
      avail_evt     <= push_ok && (!ctrl2[`C2_ADDR] || msb);
      ovr_evt       <= fifo.push && !push_ok;
      addr_evt      <= push_ok && ctrl2[`C2_ADDR] && msb;
      tx_empty_prev <= TX_EMPTY;
      tx_idle_prev  <= TX_IDLE;
    end
  end

  // noise never appears here; it only rides on the data event
  assign irq_any = (ctrl2[`C2_RIE] && (avail_evt || ovr_evt))
                 || (ctrl2[`C2_TEIE] && TX_EMPTY && !tx_empty_prev)
                 || (ctrl2[`C2_TIIE] && TX_IDLE && !tx_idle_prev)
                 || addr_evt || wake_fire;

  always_ff @(posedge CLOCK or posedge RST)
  begin
    if (RST)
      IRQ_N <= 1'b1;
    else
      IRQ_N <= !(irq_any && ctrl3[`C3_GLOBAL] && ctrl3[`C3_UART]);
  end

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  AST_NOISE_WITH_READY: assert property (@(posedge CLOCK) disable iff (RST)
    fifo.empty && fifo.push && fifo.push_word.noise |=> status[`ST_READY] && status[`ST_NOISE])
    else $error("noise flag not raised with ready flag");
  AST_NOISY_STORED: assert property (@(posedge CLOCK) disable iff (RST)
    fifo.push && fifo.push_word.noise && !fifo.full |=> !fifo.empty)
    else $error("noisy word was not stored");
  AST_QUIET_NO_IRQ: assert property (@(posedge CLOCK) disable iff (RST)
    !irq_any |=> IRQ_N)
    else $error("interrupt pulse without a source");
  AST_POP_NEEDS_SEQUENCE: assert property (@(posedge CLOCK) disable iff (RST)
    fifo.pop |-> armed && RD && (ADDR == `REG_DATA))
    else $error("buffer popped outside the status then data sequence");
  AST_FRAMING: assert property (@(posedge CLOCK) disable iff (RST)
    fifo.push && !maj |-> fifo.push_word.framing_error_flag)
    else $error("low stop bit without framing error");
  AST_OVERRUN_KEEPS: assert property (@(posedge CLOCK) disable iff (RST)
    fifo.push && fifo.full && !fifo.pop |=> ovr_flag && fifo.full && $stable(fifo.head))
    else $error("overrun not flagged or buffer disturbed");
  AST_ADDR_FILTER: assert property (@(posedge CLOCK) disable iff (RST)
    push_ok && ctrl2[`C2_ADDR] && !msb |=> !avail_evt ##1 (IRQ_N || $past(irq_any)))
    else $error("data interrupt for a non-address word");
  AST_FREEZE: assert property (@(posedge CLOCK) disable iff (RST)
    CLK_STOP && $past(CLK_STOP) && rx_enabled |-> $stable(os_cnt) && $stable(div_cnt))
    else $error("receiver moved while the clock was stopped");
  AST_WAKE_HELD: assert property (@(posedge CLOCK) disable iff (RST)
    WAKE |-> !wake_fire [*2] ##0 (recov_cnt == RECOVERY_LOAD))
    else $error("wake interrupt before recovery elapsed");
  AST_WAKE_GATED: assert property (@(posedge CLOCK) disable iff (RST)
    wake_fire && !ctrl3[`C3_UART] |=> IRQ_N)
    else $error("wake interrupt with uart enable clear");
endmodule : uart_rx_error_irq_wakeup

// ---- uart_rx_error_irq_wakeup_bench.sv ----
// self-checking bench for the receive, error, interrupt and wake-up block
`timescale 1ns/1ns
`include "uart_rx_consts.svh"
module uart_rx_error_irq_wakeup_bench;
  logic       CLOCK = 1'b0, RST = 1'b1, WR = 1'b0, RD = 1'b0;
  logic       CLK_STOP = 1'b0, TX_EMPTY = 1'b0, TX_IDLE = 1'b0, two_stop = 1'b0;
  logic [2:0] ADDR = 3'h0;
  logic [7:0] WDATA = 8'h00;
  logic [7:0] RDATA;
  logic       RXTX, IRQ_N, WAKE;
  int         fail_count = 0, comparisons = 0, irqs = 0, wakes = 0;
  // status bit masks: ready, noise, framing, parity, overrun
  localparam logic [7:0] ERRS = 8'h2f, RDY = 8'h20, NSE = 8'h02, FER = 8'h04, PER = 8'h01, OVR = 8'h08;

  always #10 CLOCK = ~CLOCK;

  // recovery long enough that a whole frame fits inside it
  uart_rx_error_irq_wakeup #(.RECOVERY_CYCLES(200), .WORD_DEPTH(2)) uart_rx_error_irq_wakeup_inst (
    .CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .RXTX(RXTX), .CLK_STOP(CLK_STOP), .TX_EMPTY(TX_EMPTY), .TX_IDLE(TX_IDLE), .IRQ_N(IRQ_N), .WAKE(WAKE));
  serial_sender serial_sender_inst (.clk(CLOCK), .line(RXTX));

  always @(posedge CLOCK)
  begin
    if (IRQ_N === 1'b0) irqs++;
    if (WAKE === 1'b1) wakes++;
  end

  //------------------------------------------------------------
  // shared tasks
  //------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    ADDR <= a; WDATA <= d; WR <= 1'b1;
    @(posedge CLOCK);
    WR <= 1'b0;
  endtask : wr

  task automatic expect_rd(input string name, input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge CLOCK);
    ADDR <= a; RD <= 1'b1;
    @(posedge CLOCK);
    RD <= 1'b0;
    #1 check(name, exp & m, RDATA & m);
  endtask : expect_rd

  // status read arms the pop, data read then takes the head word
  task automatic take(input string name, input logic [7:0] st, input logic [7:0] dat);
    expect_rd({name, " status"}, `REG_STATUS, ERRS, st);
    expect_rd({name, " data"}, `REG_DATA, 8'hff, dat);
  endtask : take

  // f: 0 nine bits, 1 bad parity, 2 bad stop, 3 noisy
  task automatic tx(input logic [8:0] d, input int par = 0, input logic [3:0] f = 4'h0);
    serial_sender_inst.send(d, f[0], two_stop, par, f[1], f[2], f[3]);
  endtask : tx

  task automatic irq_is(input string name, input int exp);
    check(name, 8'(exp), 8'(irqs));
  endtask : irq_is

  //------------------------------------------------------------
  // scenarios
  //------------------------------------------------------------
  task automatic t_reset;
    logic [2:0] regs [4] = '{`REG_CTRL1, `REG_CTRL2, `REG_CTRL3, `REG_BAUD};
    foreach (regs[i]) expect_rd("reg reset", regs[i], 8'hff, 8'h00);
    expect_rd("status reset", `REG_STATUS, ERRS, 8'h00);
    wr(`REG_STATUS, 8'hff);
    expect_rd("status write", `REG_STATUS, ERRS, 8'h00);
    // data read after the status reads leaves the clear sequence disarmed
    expect_rd("data reset", `REG_DATA, 8'hff, 8'h00);
  endtask : t_reset

  task automatic t_plain;
    int n = irqs;
    tx(9'h0a5);
    irq_is("irq plain", n + 1);
    expect_rd("unarmed data", `REG_DATA, 8'hff, 8'ha5);
    take("plain", RDY, 8'ha5);
    expect_rd("ready cleared", `REG_STATUS, ERRS, 8'h00);
  endtask : t_plain

  task automatic t_noise;
    int n = irqs;
    tx(9'h03c, 0, 4'h8);
    irq_is("irq noise", n + 1);
    take("noise", RDY | NSE, 8'h3c);
    expect_rd("noise cleared", `REG_STATUS, ERRS, 8'h00);
  endtask : t_noise

  task automatic t_frame;
    wr(`REG_CTRL1, 8'h18);
    two_stop = 1'b1;
    tx(9'h081, 0, 4'h4);
    tx(9'h042);
    take("framing", RDY | FER, 8'h81);
    take("after framing", RDY, 8'h42);
    two_stop = 1'b0;
    wr(`REG_CTRL1, 8'h10);
  endtask : t_frame

  task automatic t_parity;
    for (int m = 1; m <= 2; m++)
    begin
      wr(`REG_CTRL1, 8'h12 | ((m == 2) ? 8'h04 : 8'h00));
      tx(9'h037, m);
      tx(9'h037, m, 4'h2);
      take("parity good", RDY, 8'h37);
      take("parity bad", RDY | PER, 8'h37);
    end
    wr(`REG_CTRL1, 8'h10);
  endtask : t_parity

  task automatic t_overrun;
    tx(9'h011);
    tx(9'h022);
    tx(9'h033);
    take("overrun first", RDY | OVR, 8'h11);
    take("overrun second", RDY, 8'h22);
    expect_rd("overrun empty", `REG_STATUS, ERRS, 8'h00);
  endtask : t_overrun

  task automatic t_mask;
    int n;
    wr(`REG_CTRL2, 8'h11);
    n = irqs;
    tx(9'h055);
    irq_is("rx masked", n);
    take("masked", RDY, 8'h55);
    @(posedge CLOCK) TX_IDLE <= 1'b1;
    repeat (6) @(posedge CLOCK) TX_EMPTY <= 1'b1;
    irq_is("tx empty only", n + 1);
    wr(`REG_CTRL2, 8'h21);
    TX_IDLE <= 1'b0;
    repeat (2) @(posedge CLOCK) TX_IDLE <= 1'b1;
    repeat (6) @(posedge CLOCK);
    irq_is("tx idle", n + 2);
    TX_EMPTY <= 1'b0;
    TX_IDLE <= 1'b0;
  endtask : t_mask

  task automatic t_addr;
    int n;
    // parity stays off while address mode is used
    // receive enable on, so only the address filter can hold back the pulse
    wr(`REG_CTRL2, 8'h07);
    n = irqs;
    tx(9'h005);
    irq_is("addr low", n);
    tx(9'h085);
    irq_is("addr high", n + 1);
    take("addr a", RDY, 8'h05);
    take("addr b", RDY, 8'h85);
    wr(`REG_CTRL1, 8'h11);
    // receive interrupt enable off: the address event alone must raise the pulse
    wr(`REG_CTRL2, 8'h03);
    tx(9'h080, 0, 4'h1);
    irq_is("nine low", n + 1);
    tx(9'h100, 0, 4'h1);
    irq_is("nine high", n + 2);
    take("nine a", RDY, 8'h80);
    expect_rd("ninth bit", `REG_CTRL1, 8'h20, 8'h20);
    take("nine b", RDY, 8'h00);
    wr(`REG_CTRL1, 8'h10);
  endtask : t_addr

  task automatic t_wake(input logic [7:0] g, input int inc);
    int n, w;
    wr(`REG_CTRL2, 8'h0d);
    wr(`REG_CTRL3, g);
    n = irqs;
    w = wakes;
    // no frame is in flight when the clock is stopped
    @(posedge CLOCK) CLK_STOP <= 1'b1;
    fork
      tx(9'h05a);
      begin
        for (int k = 0; k < 60 && wakes == w; k++) @(posedge CLOCK);
        CLK_STOP <= 1'b0;
      end
    join
    check("wake pulse", 8'(w + 1), 8'(wakes));
    irq_is("wake held", n);
    for (int k = 0; k < 300 && irqs == n; k++) @(posedge CLOCK);
    irq_is("wake irq", n + inc);
    expect_rd("recovery data", `REG_STATUS, RDY, 8'h00);
    expect_rd("ctrl2 kept", `REG_CTRL2, 8'hff, 8'h0d);
  endtask : t_wake

  //------------------------------------------------------------
  // closing and main sequence
  //------------------------------------------------------------
  task automatic results;
    if (fail_count == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  initial
  begin
    repeat (20000) @(posedge CLOCK);
    fail_count++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge CLOCK);
    RST <= 1'b0;
    t_reset();
    wr(`REG_CTRL1, 8'h10);
    wr(`REG_CTRL2, 8'h05);
    wr(`REG_CTRL3, 8'h03);
    t_plain();
    t_noise();
    t_frame();
    t_parity();
    t_overrun();
    t_mask();
    t_addr();
    t_wake(8'h03, 1);
    t_wake(8'h00, 0);
    results();
  end
endmodule : uart_rx_error_irq_wakeup_bench

// ---- uart_rx_pkg.sv ----
// types shared by the receive block and its word buffer
package uart_rx_pkg;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP1, RX_STOP2, RX_BREAK} rx_state_t;
  typedef struct packed {
    logic [8:0] data;
    logic       noise;
    logic       framing_error_flag;
    logic       parity_error_flag;
  } rx_word_t;
endpackage : uart_rx_pkg
